// [hw/rx_align_map.svh]
`ifndef RX_ALIGN_MAP_SVH
`define RX_ALIGN_MAP_SVH
// ==========================================================
// register offsets
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_MASK 8'h08
`define OFF_STATE 8'h0C
`define OFF_CB_SEQ1 8'h10
`define OFF_CB_SEQ2 8'h14
`define OFF_CC_SEQ1 8'h18
`define OFF_CC_SEQ2 8'h1C
// ==========================================================
// control fields
`define CTL_OOB_EN 0
`define CTL_CHK_EN 1
`define CTL_GEN_EN 2
`define CTL_ERR_LOOP 3
`define CTL_CB_EN 4
`define CTL_CB_TWO 5
`define CTL_CC_EN 6
`define CTL_CC_TWO 7
`define CTL_CB_LEN2 8
`define CTL_CC_LEN2 9
`define CTL_CHK_SEL 10
`define CTL_SKEW 12
`define CTRL_RESET 32'h0000_7000
// ==========================================================
// status bits, shared by the mask
`define ST_OOB 0
`define ST_PRBS 1
`define ST_BOND 2
`define ST_BFAIL 3
`define ST_CCINS 4
`define ST_CCDEL 5
`define ST_W 6
// ==========================================================
// sequence words: symbol0 [10:0], symbol1 [21:11]
`define SYM_W 11
`define SYM_DC 10
`define CB_SEQ1_RESET 22'h20_017C
`define CC_SEQ1_RESET 22'h20_011C
`define SEQ2_RESET 22'h00_0000
// ==========================================================
// timing and sizing
`define REF_CLK_MHZ 200
`define OOB_BURST_NS 40
`define OOB_BURST_CYC ((`OOB_BURST_NS * `REF_CLK_MHZ + 999) / 1000)
`define PPM_MAX 1250
`define PRBS_SEED 31'h7FFF_FFFF
`define P7_A 6
`define P7_B 5
`define P15_A 14
`define P15_B 13
`define P23_A 22
`define P23_B 17
`define P31_A 30
`define P31_B 27
`endif

// [hw/rx_align_pkg.sv]
package rx_align_pkg;
  // one received character with its 8b/10b qualifiers
  typedef struct packed {
    logic inv;
    logic k;
    logic [7:0] data;
  } char_t;
  // elastic buffer entry: character plus sequence marks
  typedef struct packed {
    logic cb_hit;
    logic cc_hit;
    char_t ch;
  } entry_t;
  typedef enum logic [2:0] {
    BOND_IDLE = 3'b001,
    BOND_WAIT = 3'b010,
    BOND_DONE = 3'b100
  } bond_state_t;
endpackage

// [hw/rx_align_top.sv]
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rx_align_map.svh"
// ==========================================================
// Overview of operation
// [R1] optional out-of-band burst detector when enabled
// [R2] pattern checker flags errors for self test
// [R3] pattern select input picks generated sequence
// [R4] force input inserts errors into pattern
// [R5] error loopback feeds checker flag to force
// [R6] bonding aligns all lanes on bonding sequences
// [R7] sender keeps skew below half sequence spacing
// [R8] second bonding sequence also starts bonding
// [R9] correction sequence adds or drops buffered characters
// [R10] sequence length configurable, one or two
// [R11] second correction sequence also triggers correction
// [R12] sender inserts correction sequences periodically
// [R13] buffer depth sized from ppm, max 1250
// [R14] reset sequences are K 7C and 1C
// [R15] symbols carry K, disparity, wildcard; tail wildcard
// [R16] bonding sequences leave all buffers together
module rx_align_top
  import rx_align_pkg::*;
#(
  parameter int NUM_LANES = 4,
  parameter int PPM_OFFSET = 100,
  parameter int CC_PERIOD = 5000,
  parameter int SKEW_CAP = 7
)(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic rx_link_clk,
  input wire char_t [NUM_LANES-1:0] rx_lane_char,
  input wire logic rx_oob_level,
  input wire logic rx_user_take,
  output char_t [NUM_LANES-1:0] rx_lane_out,
  output logic rx_out_valid,
  output logic rx_bonded,
  input wire logic [1:0] tx_pattern_select,
  input wire logic tx_force_pattern_error,
  output logic [7:0] tx_pattern_byte,
  output logic rx_pattern_error_flag
);
  // ========================================================
  // sizing: drift over one correction period plus skew room
  localparam int PPM_USE = (PPM_OFFSET > `PPM_MAX) ? `PPM_MAX : PPM_OFFSET; // [R13]
  localparam int DRIFT = (CC_PERIOD * 2 * PPM_USE + 999999) / 1000000;
  localparam int AW = $clog2(2 * (DRIFT + SKEW_CAP) + 4);
  localparam int DEPTH = 1 << AW;
  localparam logic [AW:0] HALF = (AW+1)'(DEPTH / 2);
  localparam logic [7:0] OOB_CYC = 8'(`OOB_BURST_CYC);

  // ========================================================
  // functions
  function automatic logic sym_ok(input logic [10:0] sym, input char_t c);
    return sym[`SYM_DC] || (sym[9:0] == c); // [R15]
  endfunction

  // symbols past the configured length are ignored
  function automatic logic seq_hit(input logic [21:0] seq, input logic len2,
                                   input char_t cur, input char_t prev);
    return len2 ? (sym_ok(seq[10:0], prev) && sym_ok(seq[21:11], cur))
                : sym_ok(seq[10:0], cur); // [R10] [R15]
  endfunction

  function automatic logic prbs_tap(input logic [30:0] s, input logic [1:0] sel);
    case (sel)
      2'h0: return s[`P7_A] ^ s[`P7_B];
      2'h1: return s[`P15_A] ^ s[`P15_B];
      2'h2: return s[`P23_A] ^ s[`P23_B];
      default: return s[`P31_A] ^ s[`P31_B];
    endcase
  endfunction

  // eight bits msb first; checker shifts in received bits
  function automatic logic [38:0] prbs_run(input logic [30:0] s, input logic [1:0] sel,
                                           input logic [7:0] din, input logic use_din);
    logic [30:0] st;
    logic [7:0] q;
    st = s;
    q = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      q[i] = prbs_tap(st, sel);
      st = {st[29:0], use_din ? din[i] : q[i]};
    end
    return {st, q};
  endfunction

  // ========================================================
  // registers
  logic [31:0] ctrl_reg;
  logic [`ST_W-1:0] status_reg, mask_reg, status_next, ev;
  logic [21:0] cb1_reg, cb2_reg, cc1_reg, cc2_reg;
  logic link_s1, link_s2, link_s3, oob_s1, oob_s2;
  char_t [NUM_LANES-1:0] lane_s1, lane_s2, prev_reg;
  logic [AW:0] wptr_reg [NUM_LANES];
  logic [AW:0] rptr_reg [NUM_LANES];
  logic [AW:0] fill [NUM_LANES];
  entry_t mem [NUM_LANES][DEPTH];
  entry_t head [NUM_LANES];
  bond_state_t bond_reg, bond_next;
  logic [3:0] skew_reg, skew_next;
  logic [7:0] oob_cnt_reg;
  logic [30:0] gen_reg, chk_reg;
  logic [2:0] warm_reg;
  logic [31:0] rd_mux;

  // ========================================================
  // control decode
  wire oob_en = ctrl_reg[`CTL_OOB_EN];
  wire chk_en = ctrl_reg[`CTL_CHK_EN];
  wire gen_en = ctrl_reg[`CTL_GEN_EN];
  wire pattern_error_loopback_option = ctrl_reg[`CTL_ERR_LOOP];
  wire cb_en = ctrl_reg[`CTL_CB_EN];
  wire cc_en = ctrl_reg[`CTL_CC_EN];
  wire [3:0] max_skew = ctrl_reg[`CTL_SKEW +: 4];
  wire [1:0] chk_sel = ctrl_reg[`CTL_CHK_SEL +: 2];
  wire link_rise = link_s2 && !link_s3;
  wire wr_ctrl = reg_write && (reg_addr == `OFF_CTRL);
  wire wr_stat = reg_write && (reg_addr == `OFF_STATUS);
  wire wr_mask = reg_write && (reg_addr == `OFF_MASK);

  // ========================================================
  // per lane write side: mark sequences, drop surplus correction chars
  logic [NUM_LANES-1:0] cb_w, cc_w, del, wr_en, ne, head_cb, ins, hold_cb, pop, rep_reg;
  entry_t [NUM_LANES-1:0] wr_entry;
  for (genvar l = 0; l < NUM_LANES; l++)
  begin : g_lane
    assign cb_w[l] = seq_hit(cb1_reg, ctrl_reg[`CTL_CB_LEN2], lane_s2[l], prev_reg[l])
      || (ctrl_reg[`CTL_CB_TWO]
      && seq_hit(cb2_reg, ctrl_reg[`CTL_CB_LEN2], lane_s2[l], prev_reg[l])); // [R8]
    assign cc_w[l] = seq_hit(cc1_reg, ctrl_reg[`CTL_CC_LEN2], lane_s2[l], prev_reg[l])
      || (ctrl_reg[`CTL_CC_TWO]
      && seq_hit(cc2_reg, ctrl_reg[`CTL_CC_LEN2], lane_s2[l], prev_reg[l])); // [R11]
    assign fill[l] = wptr_reg[l] - rptr_reg[l];
    assign del[l] = link_rise && cc_en && cc_w[l] && (fill[l] > HALF); // [R9]
    assign wr_en[l] = link_rise && !del[l] && (fill[l] != (AW+1)'(DEPTH));
    assign wr_entry[l] = '{cb_hit: cb_w[l], cc_hit: cc_w[l], ch: lane_s2[l]};
    assign ne[l] = fill[l] != '0;
    assign head[l] = mem[l][rptr_reg[l][AW-1:0]];
    assign head_cb[l] = cb_en && head[l].cb_hit;
    // repeat a correction char once while the buffer runs low, not forever
    assign ins[l] = cc_en && head[l].cc_hit && (fill[l] < HALF) && !rep_reg[l]; // [R9]
  end

  // ========================================================
  // read side and bonding: lanes already at a bonding char wait
  wire rd_go = rx_user_take && (&ne);
  wire all_cb = &head_cb;
  wire bond_fail = (bond_reg == BOND_WAIT) && (skew_reg == max_skew) && !all_cb;
  assign hold_cb = (all_cb || bond_fail) ? '0 : head_cb; // [R6] [R16]
  assign pop = rd_go ? ~(hold_cb | ins) : '0;
  wire out_ok = rd_go && (hold_cb == '0);

  // bonding state: restarts on any lane's bonding sequence
  always_comb
  begin
    bond_next = bond_reg;
    skew_next = skew_reg;
    case (bond_reg)
      BOND_IDLE, BOND_DONE:
        if (rd_go && (head_cb != '0))
        begin
          bond_next = all_cb ? BOND_DONE : BOND_WAIT; // [R6]
          skew_next = 4'h0;
        end
      BOND_WAIT:
        if (rd_go)
        begin
          if (all_cb)
            bond_next = BOND_DONE; // [R16]
          else if (bond_fail)
            bond_next = BOND_IDLE;
          else
            skew_next = skew_reg + 4'h1;
        end
      default:
        bond_next = BOND_IDLE;
    endcase
  end

  // ========================================================
  // out-of-band, pattern generator and checker
  wire oob_ev = oob_en && oob_s2 && (oob_cnt_reg == OOB_CYC - 8'h01); // [R1]
  wire [38:0] gen_run = prbs_run(gen_reg, tx_pattern_select, 8'h00, 1'b0); // [R3]
  wire force_eff = tx_force_pattern_error
    || (pattern_error_loopback_option && rx_pattern_error_flag); // [R5]
  wire chk_go = chk_en && rx_out_valid;
  wire [38:0] chk_run = prbs_run(chk_reg, chk_sel, rx_lane_out[0].data, 1'b1);
  wire chk_err = chk_go && (warm_reg == 3'h4)
    && (chk_run[7:0] != rx_lane_out[0].data); // [R2]

  // ========================================================
  // events, sticky status with write-one-to-clear, set wins
  assign ev = {(|del), (rd_go && (|(ins & ~hold_cb))), bond_fail && rd_go,
               (bond_next == BOND_DONE) && (bond_reg != BOND_DONE), chk_err, oob_ev};
  assign status_next = (status_reg & ~(wr_stat ? reg_wdata[`ST_W-1:0] : '0)) | ev;
  assign irq = |(status_reg & mask_reg);
  assign rx_bonded = (bond_reg == BOND_DONE);

  // register read mux, unmapped reads return zero
  assign rd_mux = (reg_addr == `OFF_CTRL) ? ctrl_reg
    : (reg_addr == `OFF_STATUS) ? {26'h0, status_reg}
    : (reg_addr == `OFF_MASK) ? {26'h0, mask_reg}
    : (reg_addr == `OFF_STATE) ? {16'h0, 8'(fill[0]), 7'h00, rx_bonded}
    : (reg_addr == `OFF_CB_SEQ1) ? {10'h0, cb1_reg}
    : (reg_addr == `OFF_CB_SEQ2) ? {10'h0, cb2_reg}
    : (reg_addr == `OFF_CC_SEQ1) ? {10'h0, cc1_reg}
    : (reg_addr == `OFF_CC_SEQ2) ? {10'h0, cc2_reg} : 32'h0;

  // ========================================================
  // register file
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      ctrl_reg <= `CTRL_RESET;
      status_reg <= '0;
      mask_reg <= '0;
      {cb1_reg, cb2_reg} <= {`CB_SEQ1_RESET, `SEQ2_RESET}; // [R14]
      {cc1_reg, cc2_reg} <= {`CC_SEQ1_RESET, `SEQ2_RESET}; // [R14]
      reg_rdata <= 32'h0;
    end
    else
    begin
      if (wr_ctrl) ctrl_reg <= reg_wdata;
      if (wr_mask) mask_reg <= reg_wdata[`ST_W-1:0];
      if (reg_write && reg_addr == `OFF_CB_SEQ1) cb1_reg <= reg_wdata[21:0];
      if (reg_write && reg_addr == `OFF_CB_SEQ2) cb2_reg <= reg_wdata[21:0];
      if (reg_write && reg_addr == `OFF_CC_SEQ1) cc1_reg <= reg_wdata[21:0];
      if (reg_write && reg_addr == `OFF_CC_SEQ2) cc2_reg <= reg_wdata[21:0];
      status_reg <= status_next;
      reg_rdata <= reg_read ? rd_mux : 32'h0;
    end

  // synchronisers: link clock, lane characters and oob level
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      {link_s1, link_s2, link_s3, oob_s1, oob_s2} <= 5'h00;
      lane_s1 <= '0;
      lane_s2 <= '0;
    end
    else
    begin
      {link_s1, link_s2, link_s3} <= {rx_link_clk, link_s1, link_s2};
      {oob_s1, oob_s2} <= {rx_oob_level, oob_s1};
      lane_s1 <= rx_lane_char;
      lane_s2 <= lane_s1;
    end

  // buffer storage has no reset; pointers guard every read
  always_ff @(posedge ref_clk)
    for (int l = 0; l < NUM_LANES; l++)
      if (wr_en[l]) mem[l][wptr_reg[l][AW-1:0]] <= wr_entry[l];

  // buffer pointers and previous character per lane
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      for (int l = 0; l < NUM_LANES; l++)
      begin
        wptr_reg[l] <= '0;
        rptr_reg[l] <= '0;
      end
      {prev_reg, rep_reg} <= '0;
    end
    else
      for (int l = 0; l < NUM_LANES; l++)
      begin
        if (link_rise) prev_reg[l] <= lane_s2[l];
        if (wr_en[l]) wptr_reg[l] <= wptr_reg[l] + 1'b1;
        if (pop[l]) rptr_reg[l] <= rptr_reg[l] + 1'b1; // [R9]
        if (pop[l] || (rd_go && ins[l])) rep_reg[l] <= !pop[l]; // [R9]
      end

  // outputs, bonding, oob count and pattern logic
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      rx_lane_out <= '0;
      rx_out_valid <= 1'b0;
      bond_reg <= BOND_IDLE;
      skew_reg <= 4'h0;
      oob_cnt_reg <= 8'h00;
      gen_reg <= `PRBS_SEED;
      chk_reg <= `PRBS_SEED;
      warm_reg <= 3'h0;
      tx_pattern_byte <= 8'h00;
      rx_pattern_error_flag <= 1'b0;
    end
    else
    begin
      for (int l = 0; l < NUM_LANES; l++)
        if (out_ok) rx_lane_out[l] <= head[l].ch;
      rx_out_valid <= out_ok;
      bond_reg <= bond_next;
      skew_reg <= skew_next;
      oob_cnt_reg <= !oob_s2 ? 8'h00 : (oob_cnt_reg == OOB_CYC) ? OOB_CYC : oob_cnt_reg + 8'h01;
      if (gen_en) gen_reg <= gen_run[38:8];
      tx_pattern_byte <= gen_en ? (gen_run[7:0] ^ {7'h00, force_eff}) : 8'h00; // [R4]
      if (chk_go) chk_reg <= chk_run[38:8];
      if (!chk_en) warm_reg <= 3'h0;
      else if (chk_go && warm_reg != 3'h4) warm_reg <= warm_reg + 3'h1;
      rx_pattern_error_flag <= chk_err; // [R2]
    end

  // ========================================================
  // assertions
  default clocking cb_clk @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_oob_burst: assert property (oob_ev |=> status_reg[`ST_OOB]) // [R1]
    else $error("oob burst not flagged");
  a_chk_flag: assert property (chk_err |=> rx_pattern_error_flag && status_reg[`ST_PRBS]) // [R2]
    else $error("checker error lost");
  a_gen_select: assert property (gen_en && !force_eff // [R3]
    |=> tx_pattern_byte == $past(gen_run[7:0]))
    else $error("generated byte wrong");
  a_force_error: assert property (gen_en && force_eff
    |=> tx_pattern_byte == ($past(gen_run[7:0]) ^ 8'h01)) // [R4]
    else $error("forced error missing");
  a_err_loop: assert property (gen_en && pattern_error_loopback_option && rx_pattern_error_flag // [R5]
    |=> tx_pattern_byte[0] != $past(gen_run[0]))
    else $error("error loopback broken");
  a_bond_align: assert property (bond_reg == BOND_WAIT && rd_go && all_cb
    |=> rx_bonded && $past(pop) == {NUM_LANES{1'b1}}) // [R16]
    else $error("bonding release misaligned");
  a_skew_bound: assert property (bond_reg == BOND_WAIT |-> skew_reg <= max_skew) // [R6]
    else $error("skew counter past limit");
  a_cc_delete: assert property (del[0] |=> wptr_reg[0] == $past(wptr_reg[0])) // [R9]
    else $error("correction char not dropped");
  a_cc_insert: assert property (rd_go && ins[0] |=> rptr_reg[0] == $past(rptr_reg[0])) // [R9]
    else $error("correction char not repeated");
  a_fill_bound: assert property (fill[0] <= (AW+1)'(DEPTH)) // [R13]
    else $error("buffer fill out of range");

  c_bond_done: cover property (bond_reg == BOND_WAIT ##1 rx_bonded);
  c_cc_insert: cover property (ev[`ST_CCINS]);
  c_cc_delete: cover property (ev[`ST_CCDEL]);
  c_chk_err: cover property (chk_err);
endmodule // rx_align_top
`default_nettype wire

// [bench/rx_link_partner.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// remote transmitter: one character per lane per link clock
module rx_link_partner
  import rx_align_pkg::*;
(
  output logic link_clk,
  output char_t [3:0] lanes
);
  // link clock rests low between characters, it does not run free
  initial
  begin
    link_clk = 1'h0;
    lanes = '0;
  end
  // data moves at the falling edge so it is settled across the rise
  task automatic send(input char_t [3:0] v);
    lanes = v;
    #24 link_clk = 1'h1;
    #24 link_clk = 1'h0;
  endtask
  // released lanes show a changed value, never the last character
  task automatic idle();
    lanes = ~lanes;
  endtask
endmodule // rx_link_partner
`default_nettype wire

// [bench/transceiver_rx_alignment_features_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rx_align_map.svh"
module transceiver_rx_alignment_features_bench
  import rx_align_pkg::*;
;
  logic ref_clk, reset, reg_write, reg_read, rx_oob_level, rx_user_take, rx_link_clk;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic irq, rx_out_valid, rx_bonded, rx_pattern_error_flag, tx_force_pattern_error;
  logic [1:0] tx_pattern_select;
  logic [7:0] tx_pattern_byte;
  char_t [3:0] rx_lane_char, rx_lane_out;
  int n_fail = 0;
  int num_checks = 0;
  int n_valid = 0;
  int n_err = 0;
  logic [7:0] pat [24];
  // ==========================================================
  // design and far side
  rx_align_top #(.NUM_LANES(4)) rx_align_top_i (.ref_clk, .reset, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .irq, .rx_link_clk, .rx_lane_char, .rx_oob_level,
    .rx_user_take, .rx_lane_out, .rx_out_valid, .rx_bonded, .tx_pattern_select,
    .tx_force_pattern_error, .tx_pattern_byte, .rx_pattern_error_flag);
  rx_link_partner rx_link_partner_i (.link_clk(rx_link_clk), .lanes(rx_lane_char));
  // 200 MHz clock
  initial
  begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // count output words and checker flags
  always @(posedge ref_clk)
  begin
    if (rx_out_valid === 1'h1) n_valid <= n_valid + 1;
    if (rx_pattern_error_flag === 1'h1) n_err <= n_err + 1;
  end
  // ==========================================================
  // shared tasks
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(posedge ref_clk);
    reg_write <= 1'h0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
    input string name);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge ref_clk);
    reg_read <= 1'h0;
    #1;
    chk(name, e, reg_rdata & m);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  function automatic char_t ch(input logic k, input logic [7:0] d);
    return {1'h0, k, d};
  endfunction
  task automatic send_all(input char_t c);
    rx_link_partner_i.send({4{c}});
  endtask
  task automatic burst(input int n);
    @(posedge ref_clk);
    rx_oob_level <= 1'h1;
    repeat (n) @(posedge ref_clk);
    rx_oob_level <= 1'h0;
    settle(8);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    rd(`OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_7000, "ctrl reset");
    rd(`OFF_CB_SEQ1, 32'hFFFF_FFFF, 32'h0020_017C, "bond seq");
    rd(`OFF_CC_SEQ1, 32'hFFFF_FFFF, 32'h0020_011C, "corr seq");
    rd(8'h40, 32'hFFFF_FFFF, 32'h0, "unmapped");
  endtask
  // short burst below eight cycles must not count
  task automatic t_oob();
    wr(`OFF_MASK, 32'h1);
    burst(12);
    rd(`OFF_STATUS, 32'h3F, 32'h0, "oob disabled");
    wr(`OFF_CTRL, 32'h0000_7001);
    burst(6);
    rd(`OFF_STATUS, 32'h3F, 32'h0, "oob short");
    burst(12);
    chk("oob irq", 32'h1, irq);
    rd(`OFF_STATUS, 32'h3F, 32'h1, "oob status");
    wr(`OFF_MASK, 32'h0);
    settle(2);
    chk("masked irq", 32'h0, irq);
    wr(`OFF_STATUS, 32'h1);
    wr(`OFF_MASK, 32'h1);
    settle(2);
    chk("cleared irq", 32'h0, irq);
  endtask
  // capture own generator bytes, one forced, then loop them in
  task automatic t_pat(input logic [1:0] sel);
    int e0;
    wr(`OFF_CTRL, 32'h0000_7000);
    tx_pattern_select <= sel;
    wr(`OFF_CTRL, 32'h0000_7006 | {20'h0, sel, 10'h0});
    settle(4);
    for (int i = 0; i < 24; i++)
    begin
      @(posedge ref_clk);
      tx_force_pattern_error <= (i == 12);
      #1;
      pat[i] = tx_pattern_byte;
    end
    e0 = n_err;
    for (int i = 0; i < 24; i++)
    begin
      if (i == 11) chk("clean stream", 32'(e0), 32'(n_err));
      send_all(ch(1'h0, pat[i]));
    end
    rx_link_partner_i.idle();
    settle(20);
    chk("forced error", 32'h1, 32'(n_err > e0));
    rd(`OFF_STATUS, 32'h2, 32'h2, "pattern status");
    wr(`OFF_STATUS, 32'h3F);
  endtask
  // delete with the buffer over half full via second sequence, insert when low
  task automatic t_cc();
    int v0;
    wr(`OFF_CC_SEQ2, 32'h0000_01F7);
    wr(`OFF_CTRL, 32'h0000_70C0);
    wr(`OFF_STATUS, 32'h3F);
    rx_user_take <= 1'h0;
    for (int i = 0; i < 20; i++)
      send_all((i == 19) ? ch(1'h1, 8'hF7) : ch(1'h0, 8'(i)));
    rx_link_partner_i.idle();
    settle(10);
    rd(`OFF_STATE, 32'hFF00, 32'h1300, "fill after delete");
    rd(`OFF_STATUS, 32'h30, 32'h20, "delete status");
    @(posedge ref_clk);
    rx_user_take <= 1'h1;
    v0 = n_valid;
    settle(60);
    chk("drained", 32'(v0 + 19), 32'(n_valid));
    v0 = n_valid;
    for (int i = 0; i < 6; i++)
      send_all((i == 3) ? ch(1'h1, 8'h1C) : ch(1'h0, 8'(i)));
    rx_link_partner_i.idle();
    settle(20);
    chk("inserted", 32'(v0 + 7), 32'(n_valid));
    rd(`OFF_STATUS, 32'h30, 32'h30, "insert status");
  endtask
  // lane l runs l characters late; bonding must line them up
  task automatic t_bond(input logic [7:0] bd, input logic two);
    char_t [3:0] v;
    int k;
    wr(`OFF_CB_SEQ2, 32'h100 | {24'h0, bd});
    wr(`OFF_CTRL, 32'h0000_7010 | {26'h0, two, 5'h0});
    wr(`OFF_STATUS, 32'h3F);
    wr(`OFF_MASK, 32'h4);
    fork
      for (int i = 0; i < 12; i++)
      begin
        for (int l = 0; l < 4; l++)
          v[l] = (i == 2 + l) ? ch(1'h1, bd) : ch(1'h0, 8'(8'h40 + i - l));
        rx_link_partner_i.send(v);
      end
      begin
        k = 0;
        do
        begin
          settle(1);
          k++;
        end while (!(rx_out_valid === 1'h1 && rx_lane_out[0] === ch(1'h1, bd)) && k < 1000);
        chk("bond seen", ch(1'h1, bd), rx_lane_out[0]);
        for (int l = 1; l < 4; l++)
          chk("bond lane", ch(1'h1, bd), rx_lane_out[l]);
      end
    join
    rx_link_partner_i.idle();
    settle(20);
    chk("bonded", 32'h1, rx_bonded);
    chk("bond irq", 32'h1, irq);
    for (int l = 0; l < 4; l++)
      chk("aligned lane", ch(1'h0, 8'h48), rx_lane_out[l]);
  endtask
  // mid-run reset empties the lane buffers and drops bonding
  task automatic t_reset();
    @(posedge ref_clk);
    reset <= 1'h1;
    settle(5);
    chk("reset bonded", 32'h0, rx_bonded);
    chk("reset valid", 32'h0, rx_out_valid);
    @(posedge ref_clk);
    reset <= 1'h0;
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    reset = 1'h1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_write = 1'h0;
    reg_read = 1'h0;
    rx_oob_level = 1'h0;
    rx_user_take = 1'h1;
    tx_pattern_select = 2'h0;
    tx_force_pattern_error = 1'h0;
    repeat (5) @(posedge ref_clk);
    reset <= 1'h0;
    t_regs();
    t_oob();
    for (int s = 0; s < 4; s++)
      t_pat(2'(s));
    t_cc();
    t_bond(8'h7C, 1'h0);
    t_reset();
    t_bond(8'hBC, 1'h1);
    stop_test();
  end
  // watchdog, well past the expected run of about 10 us
  initial
  begin
    #200000;
    n_fail++;
    stop_test();
  end
endmodule // transceiver_rx_alignment_features_bench
`default_nettype wire
